// File: src/cdcp_pkg.sv
/*
  Constants, types and register map of the codec slot port.
  Assumes one 125 MHz system clock and a plain address/strobe register port.
*/
// Overview of operation
// - I2S uses two slots: left audio in slot 0, right in slot 1
// - I2S never carries command or status words
// - I2S frame sync is low for all of slot 0, high otherwise
// - I2S sync and data change on clock fall; input sampled on rise
// - With data delay set, data starts one clock after the sync edge
// - I2S slots are slot_length long; data bits per slot programmable
// - One byte swap enable covers playback and record words alike
// - Byte swap reverses the byte order of each audio word
// - Swapping honours programmed slot length and bits per slot
// - Bits one nibble short of slot: playback swaps nibbles of the moved byte; record does not
// - AC-link frame: 13 slots, slot 0 is 16 clocks, others 20
// - Codec master clock is 24.576 MHz; the port makes 31.25 MHz from 125 MHz instead
// - AC-link frame sync is high for slot 0; frame starts on its rise
// - Slot 0 is the tag slot, slots 1 to 12 carry data
// - Outgoing slot 1 is command address, slot 2 command data
// - Unused slots and bits are zero; 8 to 20 bit samples fit
// - AC-link 2.0 ORs both codec inputs into one stream
// - Request flag 0 in slot 1 bits 2..11 means send slot next frame
// - On-demand sampling only with a single codec attached
// - Out valid slots from valid register; in valid slots from rx tag
package cdcp_pkg;

  // Port operating modes
  typedef enum logic [1:0] {
    CDCP_IDLE = 2'b00,
    CDCP_I2S  = 2'b01,
    CDCP_AC10 = 2'b10,
    CDCP_AC20 = 2'b11
  } cdcp_mode_t;

  // Control register layout, high bits first
  typedef struct packed {
    logic       codec_run;
    logic       od_en;
    logic       sec_en;
    logic       byte_swap_en;
    logic       data_delay_sel;
    cdcp_mode_t mode;
  } cdcp_ctrl_t;

  // Frame format register layout
  typedef struct packed {
    logic [5:0] bits_per_slot;
    logic [5:0] slot_zero_length;
    logic [5:0] slot_length;
  } cdcp_fmt_t;

  // Register offsets
  localparam logic [7:0] CDCP_CTRL_OFS  = 8'h00;
  localparam logic [7:0] CDCP_FMT_OFS   = 8'h04;
  localparam logic [7:0] CDCP_VALID_OFS = 8'h08;
  localparam logic [7:0] CDCP_CADR_OFS  = 8'h0C;
  localparam logic [7:0] CDCP_CDAT_OFS  = 8'h10;
  localparam logic [7:0] CDCP_SADR_OFS  = 8'h14;
  localparam logic [7:0] CDCP_SDAT_OFS  = 8'h18;
  localparam logic [7:0] CDCP_RTAG_OFS  = 8'h1C;

  // Reset values: AC-link frame shape, port idle
  localparam logic [6:0]  CDCP_CTRL_RST  = 7'h00;
  localparam logic [17:0] CDCP_FMT_RST   = 18'h1_4414;
  localparam logic [9:0]  CDCP_VALID_RST = 10'h000;

  // Slot numbering
  localparam logic [3:0] CDCP_I2S_LAST = 4'h1;
  localparam logic [3:0] CDCP_AC_LAST  = 4'hC;
  localparam logic [3:0] CDCP_SLOT_CMD = 4'h1;
  localparam logic [3:0] CDCP_SLOT_DAT = 4'h2;
  localparam logic [3:0] CDCP_SLOT_AUD = 4'h3;
  localparam logic [5:0] CDCP_NIBBLE   = 6'h04;
  localparam int         CDCP_REQ_LSB  = 2;

  // Clock rates in kHz and derived half periods, rounded down
  localparam int CDCP_SYS_KHZ  = 125000;
  localparam int CDCP_MCLK_KHZ = 24576;
  localparam int CDCP_SCLK_KHZ = 3072;
  localparam int CDCP_MCLK_HALF = CDCP_SYS_KHZ / (2 * CDCP_MCLK_KHZ);
  localparam int CDCP_SCLK_HALF = CDCP_SYS_KHZ / (2 * CDCP_SCLK_KHZ);

endpackage

// File: src/cdcp_port.sv
/*
  Codec slot port: I2S master and AC-link 1.0/2.0 controller with byte
  swap, command/status slots and on-demand sampling.
  Assumes audio words are offered on tx_word when tx_take pulses and that
  the register master follows a one-cycle strobe protocol.
*/
`timescale 1ns/1ps
module cdcp_port
  import cdcp_pkg::*;
#(
  parameter int MCLK_HALF = CDCP_MCLK_HALF,
  parameter int SCLK_HALF = CDCP_SCLK_HALF
)
(
  // System
  input  logic        clock,
  input  logic        sys_rst,
  // Register port
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata,
  // Audio words
  input  logic [23:0] tx_word,
  output logic        tx_take,
  output logic [3:0]  tx_slot,
  output logic [23:0] rx_word,
  output logic        rx_valid,
  output logic [3:0]  rx_slot,
  // Codec pins
  input  logic        serial_clock_pin_i,
  output logic        serial_clock_pin_o,
  output logic        serial_clock_pin_oe,
  output logic        frame_sync_pin,
  output logic        serial_out_pin,
  input  logic        serial_in_pin,
  input  logic        second_input_pin,
  output logic        codec_reset_pin_n,
  output logic        port_master_clock
);

  cdcp_ctrl_t  ctrl_q;
  cdcp_fmt_t   fmt_q;
  logic [9:0]  valid_q, req_q, fv_q;
  logic [19:0] cmd_addr_q, cmd_data_q, stat_addr_q, stat_data_q;
  logic        cmd_pend_q, cmd_frame_q;
  logic [15:0] rx_tag_q;
  logic [1:0]  sck_s_q, sin_s_q, sin2_s_q;
  logic        sck_prev_q, sclk_q, sclk_oe_q, fs_q, sdo_q, mclk_q, rstn_q;
  logic [7:0]  div_q, mdiv_q;
  logic [3:0]  slot_q, tx_slot_q, rx_slot_q;
  logic [5:0]  bit_q;
  logic [31:0] tx_sh_q, rx_sh_q, rdata_q;
  logic [23:0] rx_word_q;
  logic        tx_take_q, rx_valid_q;

  logic        i2s, ac, od_act, launch, sample, rx_bit, frame_start;
  logic        slot_start, wr_cmd, fs_lvl, ahead0, aud_slot, aud_ok;
  logic [3:0]  last_slot, slot_d;
  logic [5:0]  bit_d, len_q, len_d;
  logic [9:0]  fv_d;
  logic [15:0] tag_d;
  logic [31:0] word_d, rx_full, rx_val;
  logic [31:0] rx_mask;
  logic        in_slot0;

  assign i2s    = (ctrl_q.mode == CDCP_I2S);
  assign ac     = ctrl_q.mode[1];
  assign od_act = (ctrl_q.mode == CDCP_AC20) && ctrl_q.od_en
                  && !ctrl_q.sec_en;
  assign last_slot = i2s ? CDCP_I2S_LAST : CDCP_AC_LAST;

  // Slot length: I2S slots all use slot_length
  function automatic logic [5:0] len_of(input logic [3:0] s);
    len_of = (s == 4'h0 && !i2s) ? fmt_q.slot_zero_length
                                 : fmt_q.slot_length;
  endfunction

  // Byte reversal of the low bytes in use, result left in low bytes
  function automatic logic [23:0] rev(input logic [23:0] w,
                                      input logic [1:0]  nb);
    case (nb)
      2'h1:    rev = {16'h0000, w[7:0]};
      2'h2:    rev = {8'h00, w[7:0], w[15:8]};
      default: rev = {w[7:0], w[15:8], w[23:16]};
    endcase
  endfunction

  // Playback word to left-justified slot image
  function automatic logic [31:0] tx_fmt(input logic [23:0] w,
                                         input logic [5:0]  slen);
    logic [1:0]  nb;
    logic        nib;
    logic [31:0] r;
    nb  = 2'((fmt_q.bits_per_slot + 6'h07) >> 3);
    nib = (slen - fmt_q.bits_per_slot) == CDCP_NIBBLE;
    r   = 32'h0000_0000;
    if (!ctrl_q.byte_swap_en)
      r = {8'h00, w} << (6'd32 - fmt_q.bits_per_slot);
    else
    begin
      // Moved top byte carries the spare nibble; swapping closes the gap
      case (nb)
        2'h1:    r = {nib ? {w[3:0], w[7:4]} : w[7:0], 24'h00_0000};
        2'h2:    r = {w[7:0], nib ? {w[11:8], w[15:12]} : w[15:8],
                      16'h0000};
        default: r = {w[7:0], w[15:8],
                      nib ? {w[19:16], w[23:20]} : w[23:16], 8'h00};
      endcase
    end
    tx_fmt = r;
  endfunction

  // Pin synchronisers
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sck_s_q  <= 2'h0;
      sin_s_q  <= 2'h0;
      sin2_s_q <= 2'h0;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      sck_s_q  <= {sck_s_q[0], serial_clock_pin_i};
      sin_s_q  <= {sin_s_q[0], serial_in_pin};
      sin2_s_q <= {sin2_s_q[0], second_input_pin};
      sck_prev_q <= sck_s_q[1];
    end
  end

  // I2S bit clock made here; idles high so the first edge is a fall
  always_ff @(posedge clock)
  begin
    if (sys_rst || !i2s)
    begin
      div_q  <= 8'h00;
      sclk_q <= 1'b1;
    end
    else if (div_q == 8'(SCLK_HALF - 1))
    begin
      div_q  <= 8'h00;
      sclk_q <= !sclk_q;
    end
    else
      div_q <= div_q + 8'h01;
  end

  // Launch and sample edges per mode
  always_comb
  begin
    launch = 1'b0;
    sample = 1'b0;
    if (i2s)
    begin
      launch = (div_q == 8'(SCLK_HALF - 1)) && sclk_q;
      sample = (div_q == 8'(SCLK_HALF - 1)) && !sclk_q;
    end
    else if (ac)
    begin
      launch = sck_s_q[1] && !sck_prev_q;
      sample = !sck_s_q[1] && sck_prev_q;
    end
  end

  // Next data position; frame sync runs one bit ahead when delayed
  always_comb
  begin
    len_q = len_of(slot_q);
    if (bit_q >= len_q - 6'h01)
    begin
      bit_d  = 6'h00;
      slot_d = (slot_q >= last_slot) ? 4'h0 : slot_q + 4'h1;
    end
    else
    begin
      bit_d  = bit_q + 6'h01;
      slot_d = slot_q;
    end
    len_d  = len_of(slot_d);
    ahead0 = (slot_d == 4'h0 && bit_d != len_d - 6'h01)
             || (slot_d == last_slot && bit_d == len_d - 6'h01);
    fs_lvl = ctrl_q.data_delay_sel ? ahead0
                                   : (slot_d == 4'h0);
    slot_start  = launch && bit_d == 6'h00;
    frame_start = slot_start && slot_d == 4'h0;
  end

  // Outgoing valid slots, gated by on-demand requests
  assign fv_d = valid_q & (od_act ? ~req_q : 10'h3FF);

  // Tag word: frame valid, command slots, audio slots 3..12
  always_comb
  begin
    tag_d = 16'h0000;
    tag_d[15] = (|fv_d) || cmd_pend_q;
    tag_d[14] = cmd_pend_q;
    tag_d[13] = cmd_pend_q;
    for (int k = 0; k < 10; k++)
      tag_d[12 - k] = fv_d[k];
  end

  // Slot image to load at each slot start
  always_comb
  begin
    aud_slot = slot_d >= CDCP_SLOT_AUD;
    aud_ok   = aud_slot && fv_q[4'(slot_d - CDCP_SLOT_AUD)];
    word_d   = 32'h0000_0000;
    if (i2s)
      word_d = tx_fmt(tx_word, len_d);
    else if (slot_d == 4'h0)
      word_d = {tag_d, 16'h0000};
    else if (slot_d == CDCP_SLOT_CMD && cmd_frame_q)
      word_d = {cmd_addr_q, 12'h000};
    else if (slot_d == CDCP_SLOT_DAT && cmd_frame_q)
      word_d = {cmd_data_q, 12'h000};
    else if (aud_ok)
      word_d = tx_fmt(tx_word, len_d);
  end

  // Frame counters and outgoing shift register
  always_ff @(posedge clock)
  begin
    if (sys_rst || ctrl_q.mode == CDCP_IDLE)
    begin
      slot_q  <= 4'hF;
      bit_q   <= 6'h3F;
      tx_sh_q <= 32'h0000_0000;
      sdo_q   <= 1'b0;
      fs_q    <= 1'b0;
    end
    else if (launch)
    begin
      slot_q <= slot_d;
      bit_q  <= bit_d;
      fs_q   <= i2s ? !fs_lvl : fs_lvl;
      if (slot_start)
      begin
        sdo_q   <= word_d[31];
        tx_sh_q <= {word_d[30:0], 1'b0};
      end
      else
      begin
        sdo_q   <= tx_sh_q[31];
        tx_sh_q <= {tx_sh_q[30:0], 1'b0};
      end
    end
  end

  // Per-frame choices latched at the frame boundary
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      fv_q        <= 10'h000;
      cmd_frame_q <= 1'b0;
    end
    else if (frame_start)
    begin
      fv_q        <= ac ? fv_d : 10'h000;
      cmd_frame_q <= ac && cmd_pend_q;
    end
  end

  // Playback word request
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tx_take_q <= 1'b0;
      tx_slot_q <= 4'h0;
    end
    else
    begin
      tx_take_q <= slot_start && (i2s || aud_ok);
      if (slot_start)
        tx_slot_q <= slot_d;
    end
  end

  // Received stream; second input merged in 2.0 mode
  assign rx_bit = sin_s_q[1] || ((ctrl_q.mode == CDCP_AC20)
                  && ctrl_q.sec_en && sin2_s_q[1]);
  assign rx_full = {rx_sh_q[30:0], rx_bit};
  // Keep only the data bits; older slot bits sit above them in the shifter
  assign rx_mask = ~(32'hFFFF_FFFF << fmt_q.bits_per_slot);
  assign rx_val  = (rx_full >> (len_q - fmt_q.bits_per_slot)) & rx_mask;

  // Capture slots, decode tag, status and request flags
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_sh_q     <= 32'h0000_0000;
      rx_tag_q    <= 16'h0000;
      stat_addr_q <= 20'h0_0000;
      stat_data_q <= 20'h0_0000;
      req_q       <= 10'h3FF;
      rx_valid_q  <= 1'b0;
      rx_slot_q   <= 4'h0;
      rx_word_q   <= 24'h00_0000;
    end
    else
    begin
      rx_valid_q <= 1'b0;
      if (sample && slot_q <= last_slot)
      begin
        rx_sh_q <= rx_full;
        if (bit_q == len_q - 6'h01)
        begin
          if (!i2s && slot_q == 4'h0)
            rx_tag_q <= rx_full[15:0];
          else if (!i2s && slot_q == CDCP_SLOT_CMD)
          begin
            stat_addr_q <= rx_full[19:0];
            req_q <= rx_full[CDCP_REQ_LSB +: 10];
          end
          else if (!i2s && slot_q == CDCP_SLOT_DAT)
            stat_data_q <= rx_full[19:0];
          else if (i2s || rx_tag_q[4'hF - slot_q])
          begin
            rx_valid_q <= 1'b1;
            rx_slot_q  <= slot_q;
            rx_word_q  <= ctrl_q.byte_swap_en
                          ? rev(rx_val[23:0],
                                2'((fmt_q.bits_per_slot + 6'h07) >> 3))
                          : rx_val[23:0];
          end
        end
      end
    end
  end

  // Register writes; a software write wins over the sent-clear
  assign wr_cmd = reg_wr && reg_addr == CDCP_CDAT_OFS;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrl_q     <= cdcp_ctrl_t'(CDCP_CTRL_RST);
      fmt_q      <= cdcp_fmt_t'(CDCP_FMT_RST);
      valid_q    <= CDCP_VALID_RST;
      cmd_addr_q <= 20'h0_0000;
      cmd_data_q <= 20'h0_0000;
      cmd_pend_q <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == CDCP_CTRL_OFS)
        ctrl_q <= cdcp_ctrl_t'(reg_wdata[6:0]);
      if (reg_wr && reg_addr == CDCP_FMT_OFS)
        fmt_q <= cdcp_fmt_t'(reg_wdata[17:0]);
      if (reg_wr && reg_addr == CDCP_VALID_OFS)
        valid_q <= reg_wdata[9:0];
      if (reg_wr && reg_addr == CDCP_CADR_OFS)
        cmd_addr_q <= reg_wdata[19:0];
      if (wr_cmd)
        cmd_data_q <= reg_wdata[19:0];
      if (wr_cmd)
        cmd_pend_q <= 1'b1;
      else if (frame_start && ac)
        cmd_pend_q <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else if (reg_rd)
      case (reg_addr)
        CDCP_CTRL_OFS:  rdata_q <= {25'h000_0000, ctrl_q};
        CDCP_FMT_OFS:   rdata_q <= {14'h0000, fmt_q};
        CDCP_VALID_OFS: rdata_q <= {22'h00_0000, valid_q};
        CDCP_CADR_OFS:  rdata_q <= {12'h000, cmd_addr_q};
        CDCP_CDAT_OFS:  rdata_q <= {cmd_pend_q, 11'h000, cmd_data_q};
        CDCP_SADR_OFS:  rdata_q <= {12'h000, stat_addr_q};
        CDCP_SDAT_OFS:  rdata_q <= {12'h000, stat_data_q};
        CDCP_RTAG_OFS:  rdata_q <= {6'h00, req_q, rx_tag_q};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    else
      rdata_q <= 32'h0000_0000;
  end

  // Master clock divider; half period rounded down, not exact 24.576 MHz
  always_ff @(posedge clock)
  begin
    if (sys_rst || !ac)
    begin
      mdiv_q <= 8'h00;
      mclk_q <= 1'b0;
    end
    else if (mdiv_q == 8'(MCLK_HALF - 1))
    begin
      mdiv_q <= 8'h00;
      mclk_q <= !mclk_q;
    end
    else
      mdiv_q <= mdiv_q + 8'h01;
  end

  // Pin drivers from flops
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sclk_oe_q <= 1'b0;
      rstn_q    <= 1'b0;
    end
    else
    begin
      sclk_oe_q <= i2s;
      rstn_q    <= ctrl_q.codec_run;
    end
  end

  assign reg_rdata           = rdata_q;
  assign tx_take             = tx_take_q;
  assign tx_slot             = tx_slot_q;
  assign rx_word             = rx_word_q;
  assign rx_valid            = rx_valid_q;
  assign rx_slot             = rx_slot_q;
  assign serial_clock_pin_o  = sclk_q;
  assign serial_clock_pin_oe = sclk_oe_q;
  assign frame_sync_pin      = fs_q;
  assign serial_out_pin      = sdo_q;
  assign codec_reset_pin_n   = rstn_q;
  assign port_master_clock   = mclk_q;

  // Slot 0 as the pins show it; one bit early when data delay is set
  assign in_slot0 = ctrl_q.data_delay_sel
                    ? ((slot_q == 4'h0 && bit_q != len_q - 6'h01)
                       || (slot_q == last_slot && bit_q == len_q - 6'h01))
                    : (slot_q == 4'h0);

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_launch;
    launch ##1 1'b1;
  endsequence

  a_i2s_two_slots: assert property (i2s && slot_q != 4'hF |-> slot_q <= 4'h1)
    else $error("i2s slot out of range");
  a_i2s_no_cmd: assert property (i2s && frame_start |=> !cmd_frame_q)
    else $error("command slot in i2s");
  a_i2s_sync_low: assert property (i2s && slot_q != 4'hF
    |-> fs_q == !in_slot0)
    else $error("i2s sync level wrong");
  a_i2s_out_edge: assert property (i2s && sample |=> $stable(sdo_q))
    else $error("data moved on rising edge");
  a_ac_sync_high: assert property (ac && slot_q != 4'hF
    |-> fs_q == in_slot0)
    else $error("ac sync level wrong");
  a_ac_slot_range: assert property (ac && slot_q != 4'hF
    |-> slot_q <= 4'hC)
    else $error("ac slot out of range");
  a_rx_or_merge: assert property (sample && slot_q <= last_slot
    |=> rx_sh_q[0] == $past(rx_bit))
    else $error("receive bit lost");
  a_od_request: assert property (frame_start && od_act
    |=> (fv_q & $past(req_q)) == 10'h000)
    else $error("slot sent without request");
  a_slot_start_load: assert property (s_launch and (slot_start ##1 1'b1)
    |-> sdo_q == $past(word_d[31]))
    else $error("slot image not loaded");

endmodule

// File: verification/cdcp_codec_model.sv
/*
  Behavioural codec for the slot port: free bit clock, two serial
  return streams and a capture of each outgoing frame.
  Assumes the bench loads rx_a/rx_b and waits on fr.
*/
`timescale 1ns/1ps
module cdcp_codec_model (
  // Bench control
  input  wire logic ac_on,
  input  wire logic i2s_on,
  // Link pins
  input  wire logic sck,
  input  wire logic fs,
  input  wire logic sdo,
  output logic      bclk,
  output logic      sdi,
  output logic      sdi2
);
  logic [255:0] rx_a, rx_b, cap, capfs, last, lastfs;
  int           pos, flen, nfr;
  logic         act_q;
  event         fr;
  // Sample edge: AC on clock fall, I2S on rise
  wire          smp = i2s_on ? sck : ~sck;
  wire          act = i2s_on ? ~fs : fs;

  // Bit clock runs free; odd start keeps it off the system phase
  initial
  begin
    {rx_a, rx_b, act_q, sdi, sdi2} = '0;
    pos  = 0;
    nfr  = 0;
    bclk = 1'b0;
    #13;
    forever #80 bclk = ac_on ? ~bclk : 1'b0;
  end

  // Restart the frame at the sync's active edge, snapshot the last one
  always @(posedge smp)
  begin
    if (act && !act_q)
    begin
      last   = cap;
      lastfs = capfs;
      flen   = pos + 1;
      pos    = 0;
      nfr++;
      -> fr;
    end
    else
      pos = (pos + 1) % 256;
    act_q          = act;
    cap[255-pos]   = sdo;
    capfs[255-pos] = fs;
  end

  // Fixed frame length, so a restart only costs the first bit
  always @(negedge smp)
  begin
    sdi  <= rx_a[255 - ((pos + 1) % (i2s_on ? 64 : 256))];
    sdi2 <= rx_b[255 - ((pos + 1) % (i2s_on ? 64 : 256))];
  end
endmodule

// File: verification/tb_cdcp_port.sv
/*
  Self-checking bench for the codec slot port against a codec model.
  Assumes cdcp_pkg and cdcp_codec_model; random words from a fixed seed.
*/
`timescale 1ns/1ps
module tb_cdcp_port
  import cdcp_pkg::*;
();
  logic         clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]   reg_addr = '0;
  logic [31:0]  reg_wdata = '0, reg_rdata;
  logic [23:0]  tx_word = '0, rx_word, rxl, rxr;
  logic [3:0]   tx_slot, rx_slot;
  logic         tx_take, rx_valid, sck_o, sck_oe, fs, sdo, sdi, sdi2;
  logic         codec_rst_n, mclk, bclk, ac_on = 0, i2s_on = 0;
  logic [15:0]  tk = '0;
  logic         mk;
  logic [23:0]  rxw [16];
  logic [255:0] lf;
  logic [19:0]  ca, cd, ra, rdat, a3, b4;
  int           err_count = 0, n_checks = 0;
  // Bit clock wire: port drives it in I2S, codec otherwise
  wire          sck = sck_oe ? sck_o : bclk;

  cdcp_port #(.MCLK_HALF(1), .SCLK_HALF(3)) cdcp_port_inst (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_word(tx_word), .tx_take(tx_take),
    .tx_slot(tx_slot), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_slot(rx_slot), .serial_clock_pin_i(sck),
    .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
    .frame_sync_pin(fs), .serial_out_pin(sdo), .serial_in_pin(sdi),
    .second_input_pin(sdi2), .codec_reset_pin_n(codec_rst_n),
    .port_master_clock(mclk));

  cdcp_codec_model cdcp_codec_model_inst (
    .ac_on(ac_on), .i2s_on(i2s_on), .sck(sck), .fs(fs), .sdo(sdo),
    .bclk(bclk), .sdi(sdi), .sdi2(sdi2));

  always #4 clock = ~clock;

  // Newest record word per slot, and slots that took a playback word
  always @(posedge clock)
  begin
    if (rx_valid === 1'b1)
      rxw[rx_slot] <= rx_word;
    if (tx_take === 1'b1)
      tk[tx_slot] <= 1'b1;
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One-cycle strobes, changed just after the edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask

  // Wait n frame starts, then take the last frame minus the data delay
  task automatic frames(int n);
    repeat (n) @(cdcp_codec_model_inst.fr);
    lf = cdcp_codec_model_inst.last << 1;
  endtask

  function automatic logic [23:0] fld(int p, int w);
    fld = '0;
    for (int i = 0; i < w; i++)
      fld = {fld[22:0], lf[255-p-i]};
  endfunction

  function automatic logic [23:0] sl(int k);
    sl = fld(16 + 20 * (k - 1), 20);
  endfunction

  // Logical AC frame, shifted one bit for the data delay
  function automatic logic [255:0] mkac(logic [15:0] t,
    logic [19:0] s1, s2, s3, s4);
    mkac = {t, s1, s2, s3, s4, 160'h0} >> 1;
  endfunction

  function automatic logic [23:0] swp(logic [23:0] w);
    swp = {w[7:0], w[15:8], w[23:16]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog sized for about eighteen AC frames
  initial
  begin
    repeat (95000) @(posedge clock);
    err_count++;
    test_done();
  end

  initial
  begin
    void'($urandom(92434));
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    // Reset values and a hole in the map
    rd(CDCP_FMT_OFS, 32'h0001_4414, "fmt");
    rd(CDCP_CTRL_OFS, 32'h0000_0000, "ctrl");
    rd(CDCP_RTAG_OFS, 32'h03FF_0000, "rtag");
    rd(8'h40, 32'h0000_0000, "hole");
    chk("sck idle", 32'h1, {31'h0, sck_o});
    // AC-link 1.0: command slots, audio 3 and 4, status return
    ca   = 20'($urandom);
    cd   = 20'($urandom);
    ra   = {8'($urandom), 10'h3FF, 2'b00};
    rdat = 20'($urandom);
    a3   = 20'($urandom);
    cdcp_codec_model_inst.rx_a = mkac(16'hF000, ra, rdat, a3, 20'h0);
    wr(CDCP_VALID_OFS, 32'h0000_0003);
    tx_word <= 24'($urandom) & 24'h0F_FFFF;
    ac_on   <= 1'b1;
    wr(CDCP_CTRL_OFS, 32'h0000_0046);
    frames(2);
    repeat (1000) @(posedge clock);
    wr(CDCP_CADR_OFS, {12'h0, ca});
    wr(CDCP_CDAT_OFS, {12'h0, cd});
    frames(2);
    chk("tag", 32'h7800, {17'h0, lf[254:240]});
    chk("cmd adr", {12'h0, ca}, sl(1));
    chk("cmd dat", {12'h0, cd}, sl(2));
    chk("slot3", tx_word, sl(3));
    chk("slot4", tx_word, sl(4));
    chk("slot5", 32'h0, sl(5));
    chk("sync hi", 32'hFFFF, cdcp_codec_model_inst.lastfs[255:240]);
    chk("sync lo", 32'h0, {31'h0, |cdcp_codec_model_inst.lastfs[239:0]});
    chk("ac len", 32'd256, 32'(cdcp_codec_model_inst.flen));
    chk("codec run", 32'h1, {31'h0, codec_rst_n});
    chk("takes", 32'h0018, {16'h0, tk});
    @(posedge clock) #1 mk = mclk;
    @(posedge clock) #1 chk("mclk", {31'h0, ~mk}, {31'h0, mclk});
    frames(1);
    chk("tag idle", 32'h1800, {17'h0, lf[254:240]});
    chk("cmd idle", 32'h0, sl(1));
    rd(CDCP_SADR_OFS, {12'h0, ra}, "stat adr");
    rd(CDCP_SDAT_OFS, {12'h0, rdat}, "stat dat");
    rd(CDCP_RTAG_OFS, 32'h03FF_F000, "rx tag");
    chk("rec slot3", {4'h0, a3}, rxw[3]);
    // AC-link 2.0: second codec returns slot 4 only
    b4 = 20'($urandom);
    cdcp_codec_model_inst.rx_a = mkac(16'hF800, ra, rdat, a3, 20'h0);
    cdcp_codec_model_inst.rx_b = mkac(16'h0, 20'h0, 20'h0, 20'h0, b4);
    wr(CDCP_CTRL_OFS, 32'h0000_0057);
    frames(2);
    chk("in2 slot4", {4'h0, b4}, rxw[4]);
    chk("in1 slot3", {4'h0, a3}, rxw[3]);
    // On-demand: all request flags idle, slots held back
    cdcp_codec_model_inst.rx_b = '0;
    wr(CDCP_CTRL_OFS, 32'h0000_0067);
    frames(1);
    tk = '0;
    frames(1);
    chk("od hold", 32'h0, sl(3) | sl(4));
    chk("od takes", 32'h0, {16'h0, tk});
    // Second input on: on-demand no longer applies
    wr(CDCP_CTRL_OFS, 32'h0000_0077);
    frames(2);
    chk("od off", tx_word, sl(3));
    // All flags requesting: data follows in the next frame
    wr(CDCP_CTRL_OFS, 32'h0000_0067);
    cdcp_codec_model_inst.rx_a = mkac(16'hF800, {ra[19:12], 12'h0},
                                      rdat, a3, 20'h0);
    frames(3);
    chk("od send", tx_word, sl(3));
    rd(CDCP_RTAG_OFS, 32'h0000_F800, "flags");
    // I2S, 24 of 32 bits, byte swap both ways
    rxl = 24'($urandom);
    rxr = 24'($urandom);
    cdcp_codec_model_inst.rx_a = {{rxl, 8'h0, rxr, 8'h0} >> 1, 192'h0};
    ac_on  <= 1'b0;
    i2s_on <= 1'b1;
    // Idle first so the frame counters restart under the new format
    wr(CDCP_CTRL_OFS, 32'h0000_0000);
    wr(CDCP_FMT_OFS, 32'h0001_8820);
    tk = '0;
    tx_word <= 24'($urandom);
    wr(CDCP_CTRL_OFS, 32'h0000_004D);
    frames(4);
    chk("left", swp(tx_word), fld(0, 24));
    chk("right", swp(tx_word), fld(32, 24));
    chk("pad", 32'h0, fld(24, 8));
    chk("lr left", 32'h0, cdcp_codec_model_inst.lastfs[255:224]);
    chk("lr right", 32'hFFFF_FFFF, cdcp_codec_model_inst.lastfs[223:192]);
    chk("i2s len", 32'd64, 32'(cdcp_codec_model_inst.flen));
    chk("rec left", swp(rxl), rxw[0]);
    chk("rec right", swp(rxr), rxw[1]);
    chk("i2s takes", 32'h3, {16'h0, tk});
    chk("sck drive", 32'h1, {31'h0, sck_oe});
    // 20 bits in 24-bit slots, no data delay: nibbles close the gap
    wr(CDCP_CTRL_OFS, 32'h0000_0000);
    wr(CDCP_FMT_OFS, 32'h0001_4618);
    tx_word <= 24'($urandom) & 24'h0F_FFFF;
    wr(CDCP_CTRL_OFS, 32'h0000_0049);
    frames(3);
    lf = cdcp_codec_model_inst.last;
    ca = {tx_word[7:0], tx_word[15:8], tx_word[19:16]};
    chk("nibble", {12'h0, ca}, fld(0, 20));
    chk("len 24", 32'd48, 32'(cdcp_codec_model_inst.flen));
    lf = cdcp_codec_model_inst.lastfs;
    chk("lr nodly", 32'h0000_00FF, lf[255:224]);
    test_done();
  end
endmodule
